// File: bench/dsau_chk_asserts.sv
// Purpose: port checks of the access unit
// Assumes: one clock, rst sync high
// Notes: bound into every unit
`timescale 1ns/10ps
`default_nettype none
module dsau_chk
  import dsau_pkg::*;
(
  input wire logic clk, rst, rd_req, rd_byte, rd_direct, rd_postinc,
  input wire logic wr_req, wr_byte, mem_rd_en, mem_wr_lo, mem_wr_hi,
  input wire logic rd_valid, addr_trap,
  input wire logic [1:0] rd_ext,
  input wire logic [ADDR_W-1:0] rd_pointer, rd_pointer_next, wr_pointer,
  input wire logic [15:0] rd_dest_old, rd_result,
  input wire logic [EXT_W-2:0] mem_rd_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_trap; rd_req && !rd_byte && !rd_direct && rd_pointer[0]
    |=> addr_trap; endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_supp; wr_req && !wr_byte && wr_pointer[0]
    |=> !mem_wr_lo && !mem_wr_hi; endproperty
  a_supp: assert property (p_supp) else $error("write");
  property p_both; wr_req && !wr_byte && !wr_pointer[0]
    |=> mem_wr_lo && mem_wr_hi; endproperty
  a_both: assert property (p_both) else $error("lanes");
  property p_lane; wr_req && wr_byte |=>
    mem_wr_hi == $past(wr_pointer[0]) && mem_wr_lo != mem_wr_hi; endproperty
  a_lane: assert property (p_lane) else $error("lane");
  property p_seq; rd_req |=> mem_rd_en ##1 rd_valid; endproperty
  a_seq: assert property (p_seq) else $error("read");
  property p_inc; rd_req && rd_postinc && !rd_direct |=> rd_pointer_next ==
    $past(rd_pointer) + ($past(rd_byte) ? 16'h0001 : 16'h0002); endproperty
  a_inc: assert property (p_inc) else $error("step");
  property p_ea; rd_req && !rd_direct |=>
    mem_rd_word[14:0] == $past(rd_pointer[15:1]); endproperty
  a_ea: assert property (p_ea) else $error("word");
  property p_keep; rd_req && rd_byte && rd_ext == 2'b00 |=> ##1
    rd_result[15:8] == $past(rd_dest_old[15:8], 2); endproperty
  a_keep: assert property (p_keep) else $error("high");
  c_rd: cover property (rd_valid);
  c_trap: cover property (addr_trap);
  c_word: cover property (mem_wr_lo && mem_wr_hi);
endmodule
bind dsau_access_unit dsau_chk u_chk (.*);
`default_nettype wire

// File: bench/dsau_mem.sv
// Purpose: ram and sfr model beyond the unit
// Assumes: data shown while mem_rd_en is high
// Notes: idle bus shows the inverse of the last word
`timescale 1ns/10ps
`default_nettype none
module dsau_mem
  import dsau_pkg::*;
(
  input wire logic clk, mem_rd_en, mem_wr_lo, mem_wr_hi,
  input wire logic [EXT_W-2:0] mem_rd_word, mem_wr_word,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic sfr_hit
);
  logic [15:0] mem [logic [14:0]];
  logic [15:0] last = 16'h5A5A;
  logic [15:0] t;
  int seq = 0;
  function automatic logic [15:0] rd(input logic [14:0] w);
    return mem.exists(w) ? mem[w] : {w, 1'b0} ^ 16'hA5C3;
  endfunction
  assign sfr_hit = mem_rd_word[14:11] != 4'h0 || mem_rd_word[2:0] != 3'h7;
  always @(mem_rd_en, mem_rd_word, seq, last)
    mem_rdata = mem_rd_en ? rd(mem_rd_word[14:0]) : ~last;
  always @(posedge clk) begin
    if (mem_rd_en) last <= mem_rdata;
    t = rd(mem_wr_word[14:0]);
    if (mem_wr_lo) t[7:0] = mem_wdata[7:0];
    if (mem_wr_hi) t[15:8] = mem_wdata[15:8];
    if (mem_wr_lo || mem_wr_hi) mem[mem_wr_word[14:0]] = t;
    seq <= seq + 1;
  end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Purpose: random bench of the access unit
// Assumes: inputs driven on the falling edge
// Notes: ram end lowered to test zero reads
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dsau_pkg::*;
  localparam logic [15:0] RAM_END = 16'h7FFF;
  logic clk, rst, page_write_rd, page_write_wr, rd_req, rd_byte, rd_direct;
  logic rd_postinc, wr_req, wr_byte, wr_postinc, mem_rd_en, sfr_hit;
  logic mem_wr_lo, mem_wr_hi, rd_valid, addr_trap, v1, v2, lo, hi, trap, ok;
  logic [PAGE_W-1:0] page_wdata, read_page_register, write_page_register;
  logic [NEAR_W-1:0] rd_direct_addr;
  logic [1:0] rd_ext;
  logic [15:0] rd_pointer, rd_dest_old, wr_pointer, wr_data, mem_rdata;
  logic [15:0] mem_wdata, rd_result, rd_pointer_next, wr_pointer_next;
  logic [EXT_W-2:0] mem_rd_word, mem_wr_word;
  logic [15:0] mir [logic [14:0]];
  logic [15:0] ea, d, r1, r2, rp, wp, wd;
  logic [14:0] rw, ww;
  logic [8:0] rpg, wpg;
  logic [7:0] rq, wq;
  logic [31:0] seed = 32'h233E, x, y;
  logic [3:0] top [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
  int failures = 0, num_checks = 0;
  dsau_access_unit #(.RAM_LAST(RAM_END)) uut (.*);
  dsau_mem mem (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] pat(input logic [14:0] w);
    return mir.exists(w) ? mir[w] : {w, 1'b0} ^ 16'hA5C3;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial begin
    rst = 1;
    {page_write_rd, page_write_wr, page_wdata, rd_req, rd_byte, rd_direct,
     rd_direct_addr, rd_pointer, rd_postinc, rd_ext, rd_dest_old, wr_req,
     wr_byte, wr_pointer, wr_postinc, wr_data} = '0;
    {v1, v2, lo, hi, trap, rp, wp, rw, ww, wd, r1, r2, rq, wq} = '0;
    rpg = PAGE_RESET;
    wpg = PAGE_RESET;
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 0;
    repeat (3000) begin
      chk("rd_en", mem_rd_en, v1);
      chk("rd_word", mem_rd_en ? mem_rd_word[14:0] : 0, v1 ? rw : 0);
      chk("rd_page", mem_rd_en ? mem_rd_word[22:15] : 0, v1 ? rq : 0);
      chk("wr_page", lo | hi ? mem_wr_word[22:15] : wq, wq);
      chk("rd_ptr", rd_pointer_next, rp);
      chk("wr_ptr", wr_pointer_next, wp);
      chk("lanes", {mem_wr_hi, mem_wr_lo}, {hi, lo});
      chk("wr_word", lo | hi ? mem_wr_word[14:0] : ww, ww);
      chk("wdata", lo | hi ? mem_wdata : wd, wd);
      chk("trap", addr_trap, trap);
      chk("valid", rd_valid, v2);
      chk("result", v2 ? rd_result : r2, r2);
      chk("pages", {read_page_register,
        write_page_register}, {rpg, wpg});
      v2 = v1;
      r2 = r1;
      x = xs();
      y = xs();
      {rd_req, rd_byte, rd_postinc, wr_req, wr_byte, wr_postinc} = x[5:0];
      rd_direct = x[6] & x[7];
      rd_ext = x[9:8] == 2'd3 ? 2'd0 : x[9:8];
      rd_pointer = {top[x[11:10]], x[23:12]};
      rd_direct_addr = y[12:0];
      rd_dest_old = y[31:16];
      wr_pointer = {top[y[14:13]], x[31:20]};
      wr_data = x[31:16] ^ y[15:0];
      page_write_rd = &y[2:0];
      page_write_wr = &y[5:3];
      page_wdata = x[31:23];
      rq = rpg[7:0];
      wq = wpg[7:0];
      if (page_write_rd) rpg = page_wdata;
      if (page_write_wr) wpg = page_wdata;
      ea = rd_direct ? {3'h0, rd_direct_addr} : rd_pointer;
      v1 = rd_req;
      rw = ea[15:1];
      d = (ea < 16'h1000 ? ea[3:1] != 3'h7 : ea <= RAM_END) ? pat(rw) : 0;
      r1 = rd_byte ? {rd_dest_old[15:8], ea[0] ? d[15:8] : d[7:0]} : d;
      if (rd_ext == 2'd1) r1[15:8] = {8{r1[7]}};
      if (rd_ext == 2'd2) r1[15:8] = 8'h00;
      if (rd_req) rp = rd_pointer + (!rd_postinc || rd_direct ? 16'h0000 :
        rd_byte ? STEP_BYTE : STEP_WORD);
      trap = (rd_req && !rd_byte && ea[0]) ||
        (wr_req && !wr_byte && wr_pointer[0]);
      ok = wr_req && (wr_byte || !wr_pointer[0]);
      lo = ok && !(wr_byte && wr_pointer[0]);
      hi = ok && !(wr_byte && !wr_pointer[0]);
      ww = wr_pointer[15:1];
      wd = wr_byte ? {2{wr_data[7:0]}} : wr_data;
      if (wr_req) wp = wr_pointer + (!(ok && wr_postinc) ? 16'h0000 :
        wr_byte ? STEP_BYTE : STEP_WORD);
      d = pat(ww);
      if (lo) d[7:0] = wd[7:0];
      if (hi) d[15:8] = wd[15:8];
      if (ok) mir[ww] = d;
      @(negedge clk);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: common/dsau_pkg.sv
// Purpose: constants for the data space access unit
// Assumes: 16-bit byte addresses, word-wide memory of two byte lanes
// Notes: sizes follow the documented memory map
package dsau_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_W = 9;
  localparam int EXT_W = 24;
  localparam logic [15:0] SFR_BASE = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h0FFF;
  localparam logic [15:0] NEAR_LAST = 16'h1FFF;
  localparam int NEAR_W = 13;
  localparam logic [15:0] RAM_BASE = 16'h1000;
  localparam logic [15:0] RAM_LAST_MAX = 16'hCFFF;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 9'h001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    DSAU_EXT_NONE = 2'b00,
    DSAU_EXT_SIGN = 2'b01,
    DSAU_EXT_ZERO = 2'b10
  } dsau_ext_type;
endpackage

// File: design/dsau_access_unit.sv
// Purpose: data space access steering between core and two-lane memory
// Assumes: memory and sfr read data arrive one cycle after the request
// Notes: one read and one write port, each with its own address path
`timescale 1ns/10ps
`default_nettype none
module dsau_access_unit
  import dsau_pkg::*;
#(
  parameter logic [15:0] RAM_LAST = RAM_LAST_MAX
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // page registers
  input wire logic page_write_rd,
  input wire logic page_write_wr,
  input wire logic [PAGE_W-1:0] page_wdata,
  output logic [PAGE_W-1:0] read_page_register,
  output logic [PAGE_W-1:0] write_page_register,
  // read request from core
  input wire logic rd_req,
  input wire logic rd_byte,
  input wire logic rd_direct,
  input wire logic [NEAR_W-1:0] rd_direct_addr,
  input wire logic [ADDR_W-1:0] rd_pointer,
  input wire logic rd_postinc,
  input wire logic [1:0] rd_ext,
  input wire logic [15:0] rd_dest_old,
  // write request from core
  input wire logic wr_req,
  input wire logic wr_byte,
  input wire logic [ADDR_W-1:0] wr_pointer,
  input wire logic wr_postinc,
  input wire logic [15:0] wr_data,
  // memory side
  output logic mem_rd_en,
  output logic [EXT_W-2:0] mem_rd_word,
  input wire logic [15:0] mem_rdata,
  input wire logic sfr_hit,
  output logic mem_wr_lo,
  output logic mem_wr_hi,
  output logic [EXT_W-2:0] mem_wr_word,
  output logic [15:0] mem_wdata,
  // results to core
  output logic rd_valid,
  output logic [15:0] rd_result,
  output logic [ADDR_W-1:0] rd_pointer_next,
  output logic [ADDR_W-1:0] wr_pointer_next,
  output logic addr_trap
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // size scaled step
  function automatic logic [15:0] post_step(input logic [15:0] a,
                                            input logic inc,
                                            input logic is_byte);
    logic [15:0] s;
    s = is_byte ? STEP_BYTE : STEP_WORD;
    post_step = inc ? a + s : a;
  endfunction

  function automatic logic implemented(input logic [15:0] a);
    implemented = (a <= SFR_LAST) || (a >= RAM_BASE && a <= RAM_LAST);
  endfunction

  // ---------------------------------------------------------------
  // page registers
  // ---------------------------------------------------------------
  logic [PAGE_W-1:0] next_read_page_register;
  logic [PAGE_W-1:0] next_write_page_register;

  always_comb begin
    next_read_page_register = read_page_register;
    next_write_page_register = write_page_register;
    if (page_write_rd) begin
      next_read_page_register = page_wdata;
    end
    if (page_write_wr) begin
      next_write_page_register = page_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      read_page_register <= PAGE_RESET;
      write_page_register <= PAGE_RESET;
    end else begin
      read_page_register <= next_read_page_register;
      write_page_register <= next_write_page_register;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [15:0] rd_ea;
  logic rd_misaligned;
  logic next_mem_rd_en;
  logic [EXT_W-2:0] next_mem_rd_word;
  logic [ADDR_W-1:0] next_rd_pointer_next;
  logic pend;
  logic next_pend;
  logic pend_byte;
  logic next_pend_byte;
  logic pend_hi;
  logic next_pend_hi;
  logic pend_impl;
  logic next_pend_impl;
  logic pend_sfr;
  logic next_pend_sfr;
  logic [1:0] pend_ext;
  logic [1:0] next_pend_ext;
  logic [15:0] pend_old;
  logic [15:0] next_pend_old;
  logic next_rd_valid;
  logic [15:0] next_rd_result;
  logic [7:0] sel;

  always_comb begin
    // direct field covers near space only
    rd_ea = rd_direct ? {3'b000, rd_direct_addr} : rd_pointer;
    rd_misaligned = rd_req && !rd_byte && rd_ea[0];
    next_mem_rd_en = rd_req;
    // page joined with word address
    // page msb lies past the 16 Mbyte space, so it is dropped
    next_mem_rd_word = {read_page_register[PAGE_W-2:0], rd_ea[15:1]};
    next_rd_pointer_next = rd_req ?
      post_step(rd_pointer, rd_postinc && !rd_direct, rd_byte) :
      rd_pointer_next;
    next_pend = rd_req;
    next_pend_byte = rd_byte;
    next_pend_hi = rd_ea[0];
    next_pend_impl = implemented(rd_ea);
    next_pend_sfr = rd_ea <= SFR_LAST;
    next_pend_ext = rd_ext;
    next_pend_old = rd_dest_old;
    next_rd_result = WORD_ZERO;
    if (pend_impl && (!pend_sfr || sfr_hit)) begin
      next_rd_result = mem_rdata;
    end
    sel = pend_hi ? next_rd_result[15:8] : next_rd_result[7:0];
    if (pend_byte) begin
      next_rd_result = {pend_old[15:8], sel};
    end
    case (dsau_ext_type'(pend_ext))
      DSAU_EXT_SIGN: next_rd_result = {{8{next_rd_result[7]}},
                                       next_rd_result[7:0]};
      DSAU_EXT_ZERO: next_rd_result = {8'h00, next_rd_result[7:0]};
      default: next_rd_result = next_rd_result;
    endcase
    next_rd_valid = pend;
    if (!pend) begin
      next_rd_result = rd_result;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd_en <= 1'b0;
      mem_rd_word <= '0;
      rd_pointer_next <= '0;
      pend <= 1'b0;
      pend_byte <= 1'b0;
      pend_hi <= 1'b0;
      pend_impl <= 1'b0;
      pend_sfr <= 1'b0;
      pend_ext <= 2'b00;
      pend_old <= WORD_ZERO;
      rd_valid <= 1'b0;
      rd_result <= WORD_ZERO;
    end else begin
      mem_rd_en <= next_mem_rd_en;
      mem_rd_word <= next_mem_rd_word;
      rd_pointer_next <= next_rd_pointer_next;
      pend <= next_pend;
      pend_byte <= next_pend_byte;
      pend_hi <= next_pend_hi;
      pend_impl <= next_pend_impl;
      pend_sfr <= next_pend_sfr;
      pend_ext <= next_pend_ext;
      pend_old <= next_pend_old;
      rd_valid <= next_rd_valid;
      rd_result <= next_rd_result;
    end
  end

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  logic wr_misaligned;
  logic next_mem_wr_lo;
  logic next_mem_wr_hi;
  logic [EXT_W-2:0] next_mem_wr_word;
  logic [15:0] next_mem_wdata;
  logic [ADDR_W-1:0] next_wr_pointer_next;
  logic next_addr_trap;

  always_comb begin
    // write address formed on its own
    wr_misaligned = wr_req && !wr_byte && wr_pointer[0];
    next_mem_wr_word = {write_page_register[PAGE_W-2:0], wr_pointer[15:1]};
    next_mem_wr_lo = wr_req && wr_byte && !wr_pointer[0];
    next_mem_wr_hi = wr_req && wr_byte && wr_pointer[0];
    next_mem_wdata = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
    if (wr_req && !wr_byte && !wr_misaligned) begin
      next_mem_wr_lo = 1'b1;
      next_mem_wr_hi = 1'b1;
    end
    // write pointer held on fault for inspection; read pointer still steps on a misaligned read
    next_wr_pointer_next = wr_pointer_next;
    if (wr_req) begin
      next_wr_pointer_next = wr_misaligned ? wr_pointer :
        post_step(wr_pointer, wr_postinc, wr_byte);
    end
    next_addr_trap = rd_misaligned || wr_misaligned;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr_lo <= 1'b0;
      mem_wr_hi <= 1'b0;
      mem_wr_word <= '0;
      mem_wdata <= WORD_ZERO;
      wr_pointer_next <= '0;
      addr_trap <= 1'b0;
    end else begin
      mem_wr_lo <= next_mem_wr_lo;
      mem_wr_hi <= next_mem_wr_hi;
      mem_wr_word <= next_mem_wr_word;
      mem_wdata <= next_mem_wdata;
      wr_pointer_next <= next_wr_pointer_next;
      addr_trap <= next_addr_trap;
    end
  end

endmodule
`default_nettype wire
